// ---- design/ppc_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R01: Control bit 6 stops the port transmitter; resets to zero.
// R02: Writing one to control bit 5 restarts auto-negotiation on the port.
// R03: Control bit 4 disables far-end fault detection and pattern; port 1 only.
// R04: Control bit 3 powers down the port transceiver; resets to zero.
// R05: Control bit 2 disables auto crossover; port 2 reset value from strap.
// R06: With crossover off, control bit 1 picks straight (1) or crossed (0).
// R07: Control bit 0 loops the other port's traffic through this transceiver.
// R08: Status bit 6 reads one once auto-negotiation has completed.
// R09: Status bit 5 reads one while the port link is good.
// R10: Status bits 4..0 show partner pause, 100 full/half, 10 full/half.
// R11: Second status bit 7 picks crossover variant, resets one, no port 3 effect.
// R12: Second status bit 5 shows reversed receive polarity, transceiver ports only.
// R13: Second status bit 4 shows transmit flow control active.
// R14: Second status bit 3 shows receive flow control active.
// R15: Second status bit 2 shows speed: one for 100, zero for 10.
// R16: Second status bit 1 shows duplex: one full, zero half.
// R17: Second status bit 0 shows far-end fault on port 1 only.
// R18: Software keeps reserved second status bit 6 at zero.
// R19: Writes to read-only status bits are ignored; status stays live.
module ppc_regs (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire ppc_pkg::ppc_phy_stat_s PHY1_STATUS_I,
    input wire ppc_pkg::ppc_phy_stat_s PHY2_STATUS_I,
    input wire ppc_pkg::ppc_mii_stat_s MII_STATUS_I,
    input wire logic PORT2_CROSSOVER_OFF_STRAP_I,
    input wire logic PORT2_STRAIGHT_FORCE_STRAP_I,
    output ppc_pkg::ppc_phy_ctrl_s PHY1_CTRL_O,
    output ppc_pkg::ppc_phy_ctrl_s PHY2_CTRL_O,
    output logic IRQ_O
);

    // ==============================================================
    // State
    // ==============================================================
    typedef struct packed {
        ppc_pkg::ppc_ctl_s [1:0] ctl;
        logic [2:0] variant;
        ppc_pkg::ppc_phy_stat_s [1:0] sync1;
        ppc_pkg::ppc_phy_stat_s [1:0] sync2;
        ppc_pkg::ppc_phy_stat_s [1:0] prev;
        ppc_pkg::ppc_mii_stat_s mii_sync1;
        ppc_pkg::ppc_mii_stat_s mii_sync2;
        logic [1:0] strap_sync1;
        logic [1:0] strap_sync2;
        logic [4:0] irq_status;
        logic [4:0] irq_mask;
        logic irq;
        logic [7:0] rdata;
    } ppc_state_s;

    ppc_state_s st_reg;
    ppc_state_s st_next;

    // ==============================================================
    // Decoding helpers
    // ==============================================================
    // First status register of a transceiver port
    function automatic logic [7:0] status0(input ppc_pkg::ppc_phy_stat_s s);
        return {s.mdix, s.negotiation_complete, s.link_good, s.partner}; // R08 R09 R10
    endfunction

    // Second status register; reserved bit 6 always reads zero
    function automatic logic [7:0] status1(input logic variant, input logic pol_rev,
                                           input ppc_pkg::ppc_mii_stat_s m, input logic far_fault);
        return {variant, 1'b0, pol_rev, m.tx_fc, m.rx_fc, m.speed100, m.full_duplex, far_fault}; // R11 R13 R14 R15 R16
    endfunction

    // Common MAC-side view of a transceiver port
    function automatic ppc_pkg::ppc_mii_stat_s mac_view(input ppc_pkg::ppc_phy_stat_s s);
        return '{tx_fc: s.tx_fc, rx_fc: s.rx_fc, speed100: s.speed100, full_duplex: s.full_duplex};
    endfunction

    // Control write; the fault-disable bit only exists on the fibre port
    function automatic ppc_pkg::ppc_ctl_s ctl_write(input logic [7:0] wd, input logic fibre);
        ppc_pkg::ppc_ctl_s c;
        c = ppc_pkg::ppc_ctl_s'(wd[6:0]); // R01 R02 R04 R05 R06 R07
        c.fef_off = fibre & wd[ppc_pkg::PPC_FEF_OFF_BIT]; // R03
        return c;
    endfunction

    // ==============================================================
    // Next-state logic
    // ==============================================================
    // Synchronisers keep running in reset so the straps settle before release
    always_comb begin
        logic [4:0] events;
        logic [4:0] clear;
        logic far_fault_p1;
        events = 5'h00;
        clear = 5'h00;
        far_fault_p1 = 1'b0;
        st_next = st_reg;

        st_next.sync1[0] = PHY1_STATUS_I;
        st_next.sync1[1] = PHY2_STATUS_I;
        st_next.sync2 = st_reg.sync1;
        st_next.prev = st_reg.sync2;
        st_next.mii_sync1 = MII_STATUS_I;
        st_next.mii_sync2 = st_reg.mii_sync1;
        st_next.strap_sync1 = {PORT2_STRAIGHT_FORCE_STRAP_I, PORT2_CROSSOVER_OFF_STRAP_I};
        st_next.strap_sync2 = st_reg.strap_sync1;

        // Restart request is a one-cycle pulse; a read strobed in that cycle returns one, later reads zero
        st_next.ctl[0].renegotiate = 1'b0; // R02
        st_next.ctl[1].renegotiate = 1'b0; // R02
        st_next.rdata = ppc_pkg::PPC_RDATA_IDLE;

        // Fault detection is blanked while disabled
        far_fault_p1 = st_reg.sync2[0].far_fault & ~st_reg.ctl[0].fef_off; // R03 R17

        // Events: link changes, negotiation done, new far-end fault
        events[ppc_pkg::PPC_IRQ_LINK_P1] = st_reg.sync2[0].link_good ^ st_reg.prev[0].link_good;
        events[ppc_pkg::PPC_IRQ_LINK_P2] = st_reg.sync2[1].link_good ^ st_reg.prev[1].link_good;
        events[ppc_pkg::PPC_IRQ_AN_P1] = st_reg.sync2[0].negotiation_complete & ~st_reg.prev[0].negotiation_complete;
        events[ppc_pkg::PPC_IRQ_AN_P2] = st_reg.sync2[1].negotiation_complete & ~st_reg.prev[1].negotiation_complete;
        events[ppc_pkg::PPC_IRQ_FEF_P1] = far_fault_p1 & ~st_reg.prev[0].far_fault;

        // Register writes; status registers take only the variant bit
        if (WR_I) begin
            case (ADDR_I)
                ppc_pkg::PPC_P1_CTRL_ADDR: begin
                    st_next.ctl[0] = ctl_write(WDATA_I, 1'b1);
                end
                ppc_pkg::PPC_P2_CTRL_ADDR: begin
                    st_next.ctl[1] = ctl_write(WDATA_I, 1'b0);
                end
                ppc_pkg::PPC_P1_ST1_ADDR: begin
                    st_next.variant[0] = WDATA_I[ppc_pkg::PPC_VARIANT_BIT]; // R11 R19
                end
                ppc_pkg::PPC_P2_ST1_ADDR: begin
                    st_next.variant[1] = WDATA_I[ppc_pkg::PPC_VARIANT_BIT]; // R11 R19
                end
                ppc_pkg::PPC_P3_ST1_ADDR: begin
                    st_next.variant[2] = WDATA_I[ppc_pkg::PPC_VARIANT_BIT]; // R11 R19
                end
                ppc_pkg::PPC_IRQ_STATUS_ADDR: begin
                    clear = WDATA_I[4:0];
                end
                ppc_pkg::PPC_IRQ_MASK_ADDR: begin
                    st_next.irq_mask = WDATA_I[4:0];
                end
                default: begin
                end
            endcase
        end

        // Sticky status: a new event beats a clear in the same cycle
        st_next.irq_status = (st_reg.irq_status & ~clear) | events;

        // Register reads: live status, answered in the next cycle only
        if (RD_I) begin
            case (ADDR_I)
                ppc_pkg::PPC_P1_CTRL_ADDR: begin
                    st_next.rdata = {1'b0, st_reg.ctl[0]};
                end
                ppc_pkg::PPC_P2_CTRL_ADDR: begin
                    st_next.rdata = {1'b0, st_reg.ctl[1]};
                end
                ppc_pkg::PPC_P1_ST0_ADDR: begin
                    st_next.rdata = status0(st_reg.sync2[0]); // R19
                end
                ppc_pkg::PPC_P2_ST0_ADDR: begin
                    st_next.rdata = status0(st_reg.sync2[1]); // R19
                end
                ppc_pkg::PPC_P1_ST1_ADDR: begin
                    st_next.rdata = status1(st_reg.variant[0], st_reg.sync2[0].pol_rev,
                                            mac_view(st_reg.sync2[0]), far_fault_p1); // R12 R17
                end
                ppc_pkg::PPC_P2_ST1_ADDR: begin
                    st_next.rdata = status1(st_reg.variant[1], st_reg.sync2[1].pol_rev,
                                            mac_view(st_reg.sync2[1]), 1'b0); // R12 R17
                end
                ppc_pkg::PPC_P3_ST1_ADDR: begin
                    st_next.rdata = status1(st_reg.variant[2], 1'b0, st_reg.mii_sync2, 1'b0); // R12
                end
                ppc_pkg::PPC_IRQ_STATUS_ADDR: begin
                    st_next.rdata = {3'h0, st_reg.irq_status};
                end
                ppc_pkg::PPC_IRQ_MASK_ADDR: begin
                    st_next.rdata = {3'h0, st_reg.irq_mask};
                end
                default: begin
                    st_next.rdata = ppc_pkg::PPC_RDATA_IDLE;
                end
            endcase
        end

        // Registered interrupt level, so the pin has no glitches
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);

        // Synchronous reset; port 2 crossover bits come from the straps
        if (RST_I) begin
            st_next.ctl[0] = ppc_pkg::ppc_ctl_s'(ppc_pkg::PPC_CTL_RESET); // R01 R04
            st_next.ctl[1] = ppc_pkg::ppc_ctl_s'(ppc_pkg::PPC_CTL_RESET); // R01 R04
            st_next.ctl[1].xover_off = st_reg.strap_sync2[0]; // R05
            st_next.ctl[1].straight = st_reg.strap_sync2[1]; // R06
            st_next.variant = ppc_pkg::PPC_VARIANT_RESET; // R11
            st_next.irq_status = 5'h00;
            st_next.irq_mask = ppc_pkg::PPC_IRQ_MASK_RESET;
            st_next.irq = 1'b0;
            st_next.rdata = ppc_pkg::PPC_RDATA_IDLE;
        end
    end

    // ==============================================================
    // State register
    // ==============================================================
    always_ff @(posedge CLOCK_I) begin
        st_reg <= st_next;
    end

    // ==============================================================
    // Outputs, all straight from flip-flops
    // ==============================================================
    // Port 3 variant bit is kept for software but drives nothing
    assign PHY1_CTRL_O = '{ctl: st_reg.ctl[0], variant: st_reg.variant[0]}; // R01 R03 R04 R05 R06 R07 R11
    assign PHY2_CTRL_O = '{ctl: st_reg.ctl[1], variant: st_reg.variant[1]}; // R01 R04 R05 R06 R07 R11
    assign RDATA_O = st_reg.rdata;
    assign IRQ_O = st_reg.irq;

endmodule
`default_nettype wire

// ---- design/ppc_pkg.sv ----
`default_nettype none
package ppc_pkg;

    // ==============================================================
    // Register offsets (byte addresses on the 8-bit register port)
    // ==============================================================
    localparam logic [7:0] PPC_P1_CTRL_ADDR = 8'h1D;
    localparam logic [7:0] PPC_P1_ST0_ADDR = 8'h1E;
    localparam logic [7:0] PPC_P1_ST1_ADDR = 8'h1F;
    localparam logic [7:0] PPC_P2_CTRL_ADDR = 8'h2D;
    localparam logic [7:0] PPC_P2_ST0_ADDR = 8'h2E;
    localparam logic [7:0] PPC_P2_ST1_ADDR = 8'h2F;
    localparam logic [7:0] PPC_P3_ST1_ADDR = 8'h3F;
    localparam logic [7:0] PPC_IRQ_STATUS_ADDR = 8'hF0;
    localparam logic [7:0] PPC_IRQ_MASK_ADDR = 8'hF1;

    // ==============================================================
    // Field positions
    // ==============================================================
    localparam int PPC_VARIANT_BIT = 7;
    localparam int PPC_FEF_OFF_BIT = 4;
    localparam int PPC_IRQ_W = 5;
    localparam int PPC_IRQ_LINK_P1 = 0;
    localparam int PPC_IRQ_LINK_P2 = 1;
    localparam int PPC_IRQ_AN_P1 = 2;
    localparam int PPC_IRQ_AN_P2 = 3;
    localparam int PPC_IRQ_FEF_P1 = 4;

    // ==============================================================
    // Reset values
    // ==============================================================
    localparam logic [6:0] PPC_CTL_RESET = 7'h00;
    localparam logic [2:0] PPC_VARIANT_RESET = 3'h7;
    localparam logic [4:0] PPC_IRQ_MASK_RESET = 5'h00;
    localparam logic [7:0] PPC_RDATA_IDLE = 8'h00;

    // ==============================================================
    // Carriers
    // ==============================================================
    // Control bits 6..0 in register order
    typedef struct packed {
        logic tx_off;
        logic renegotiate;
        logic fef_off;
        logic power_down;
        logic xover_off;
        logic straight;
        logic loopback;
    } ppc_ctl_s;

    typedef struct packed {
        ppc_ctl_s ctl;
        logic variant;
    } ppc_phy_ctrl_s;

    typedef struct packed {
        logic mdix;
        logic negotiation_complete;
        logic link_good;
        logic [4:0] partner;
        logic pol_rev;
        logic tx_fc;
        logic rx_fc;
        logic speed100;
        logic full_duplex;
        logic far_fault;
    } ppc_phy_stat_s;

    typedef struct packed {
        logic tx_fc;
        logic rx_fc;
        logic speed100;
        logic full_duplex;
    } ppc_mii_stat_s;

endpackage
`default_nettype wire

// ---- testbench/ppc_regs_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppc_regs_checker (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire ppc_pkg::ppc_phy_stat_s PHY1_STATUS_I,
    input wire ppc_pkg::ppc_phy_stat_s PHY2_STATUS_I,
    input wire ppc_pkg::ppc_mii_stat_s MII_STATUS_I,
    input wire logic PORT2_CROSSOVER_OFF_STRAP_I,
    input wire logic PORT2_STRAIGHT_FORCE_STRAP_I,
    input wire ppc_pkg::ppc_phy_ctrl_s PHY1_CTRL_O,
    input wire ppc_pkg::ppc_phy_ctrl_s PHY2_CTRL_O,
    input wire logic IRQ_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    // ==========================================
    // Register port steps
    // ==========================================
    sequence wr1_s;
        WR_I && ADDR_I == 8'h1D;
    endsequence
    sequence wr2_s;
        WR_I && ADDR_I == 8'h2D;
    endsequence
    // Status must settle through the synchroniser before a read
    sequence st_s;
        $stable(PHY1_STATUS_I)[*3] ##0 RD_I && ADDR_I == 8'h1E;
    endsequence
    // ==========================================
    // Control and status checks
    // ==========================================
    a_tx_stop: assert property (wr1_s |=> PHY1_CTRL_O.ctl.tx_off == $past(WDATA_I[6]))
        else $error("tx_off not taken from write");
    a_reneg_pulse: assert property (wr1_s ##0 WDATA_I[5] ##1 !WR_I |->
        PHY1_CTRL_O.ctl.renegotiate ##1 !PHY1_CTRL_O.ctl.renegotiate) else $error("renegotiate not one pulse");
    a_fef_port2: assert property (!PHY2_CTRL_O.ctl.fef_off)
        else $error("port 2 fault disable set");
    a_pdown_write: assert property (wr2_s |=> PHY2_CTRL_O.ctl.power_down == $past(WDATA_I[3]))
        else $error("power_down not taken from write");
    a_strap_load: assert property ($fell(RST_I) |-> PHY2_CTRL_O.ctl.xover_off ==
        PORT2_CROSSOVER_OFF_STRAP_I && PHY2_CTRL_O.ctl.straight == PORT2_STRAIGHT_FORCE_STRAP_I)
        else $error("port 2 strap bits wrong after reset");
    a_straight_write: assert property (wr1_s |=> PHY1_CTRL_O.ctl.straight == $past(WDATA_I[1]))
        else $error("straight select not taken");
    a_loop_write: assert property (wr2_s |=> PHY2_CTRL_O.ctl.loopback == $past(WDATA_I[0]))
        else $error("loopback not taken");
    a_status_read: assert property (st_s |=> RDATA_O == $past(PHY1_STATUS_I[13:6]))
        else $error("status read mismatch");
    a_variant_reset: assert property ($fell(RST_I) |-> PHY1_CTRL_O.variant && PHY2_CTRL_O.variant)
        else $error("variant not one after reset");
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    ppc_pkg::ppc_phy_stat_s p1 = '0;
    ppc_pkg::ppc_phy_stat_s p2 = '0;
    ppc_pkg::ppc_mii_stat_s mii = '0;
    ppc_pkg::ppc_phy_ctrl_s c1;
    ppc_pkg::ppc_phy_ctrl_s c2;
    logic irq;
    // Strap levels; a later reset lowers the crossover-off strap to prove the capture
    logic xoff_strap = 1'b1;
    logic straight_strap = 1'b1;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [13:0] s;
    logic [13:0] pat [4] = '{14'h3FFF, 14'h2A55, 14'h15AA, 14'h0000};
    ppc_regs dut (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .PHY1_STATUS_I(p1), .PHY2_STATUS_I(p2), .MII_STATUS_I(mii),
        .PORT2_CROSSOVER_OFF_STRAP_I(xoff_strap), .PORT2_STRAIGHT_FORCE_STRAP_I(straight_strap),
        .PHY1_CTRL_O(c1), .PHY2_CTRL_O(c2), .IRQ_O(irq));
    // ==========================================
    // Clock, watchdog and helpers
    // ==========================================
    initial begin
        forever #5 clk = ~clk;
    end
    // Cut a hang short; tests need well under 1000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h1D, 8'h00);
        rd_reg(8'h2D, 8'h06);
        rd_reg(8'h1E, 8'h00);
        rd_reg(8'h3F, 8'h80);
        wr_reg(8'h1D, 8'hFF);
        rd_reg(8'h1D, 8'h5F);
        chk({1'b0, c1.ctl}, 8'h5F);
        wr_reg(8'h2D, 8'h7F);
        rd_reg(8'h2D, 8'h4F);
        wr_reg(8'h1D, 8'h20);
        #1;
        chk({7'h00, c1.ctl.renegotiate}, 8'h01);
        @(posedge clk);
        #1;
        chk({7'h00, c1.ctl.renegotiate}, 8'h00);
        // Live status on all three ports, read once the synchronisers have caught up
        foreach (pat[i]) begin
            s = pat[i];
            @(posedge clk);
            p1 <= s;
            p2 <= ~s;
            mii <= s[3:0];
            repeat (2) @(posedge clk);
            rd_reg(8'h1F, {2'b10, s[5:0]});
            rd_reg(8'h2E, ~s[13:6]);
            rd_reg(8'h2F, {2'b10, ~s[5:1], 1'b0});
            rd_reg(8'h3F, {3'b100, s[3:0], 1'b0});
            rd_reg(8'h1E, s[13:6]);
        end
        @(posedge clk);
        p1.far_fault <= 1'b1;
        wr_reg(8'h1D, 8'h10);
        rd_reg(8'h1F, 8'h80);
        wr_reg(8'h1D, 8'h00);
        rd_reg(8'h1F, 8'h81);
        wr_reg(8'h1F, 8'h00);
        rd_reg(8'h1F, 8'h01);
        chk({7'h00, c1.variant}, 8'h00);
        wr_reg(8'h1F, 8'h80);
        // Interrupt: clear, masked event, unmasked event, clear
        wr_reg(ppc_pkg::PPC_IRQ_STATUS_ADDR, 8'h1F);
        rd_reg(ppc_pkg::PPC_IRQ_STATUS_ADDR, 8'h00);
        wr_reg(ppc_pkg::PPC_IRQ_MASK_ADDR, 8'h01);
        p2.link_good <= ~p2.link_good;
        repeat (5) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h00);
        rd_reg(ppc_pkg::PPC_IRQ_STATUS_ADDR, 8'h02);
        p1.link_good <= ~p1.link_good;
        repeat (5) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr_reg(ppc_pkg::PPC_IRQ_STATUS_ADDR, 8'h01);
        rd_reg(ppc_pkg::PPC_IRQ_STATUS_ADDR, 8'h02);
        chk({7'h00, irq}, 8'h00);
        rd_reg(ppc_pkg::PPC_IRQ_MASK_ADDR, 8'h01);
        rd_reg(8'h55, 8'h00);
        // Second reset with the crossover-off strap low; straps held through it
        @(posedge clk);
        xoff_strap <= 1'b0;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h2D, 8'h02);
        rd_reg(ppc_pkg::PPC_IRQ_MASK_ADDR, 8'h00);
        print_verdict();
    end
endmodule
bind ppc_regs ppc_regs_checker u_chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PHY1_STATUS_I(PHY1_STATUS_I),
    .PHY2_STATUS_I(PHY2_STATUS_I), .MII_STATUS_I(MII_STATUS_I),
    .PORT2_CROSSOVER_OFF_STRAP_I(PORT2_CROSSOVER_OFF_STRAP_I),
    .PORT2_STRAIGHT_FORCE_STRAP_I(PORT2_STRAIGHT_FORCE_STRAP_I), .PHY1_CTRL_O(PHY1_CTRL_O),
    .PHY2_CTRL_O(PHY2_CTRL_O), .IRQ_O(IRQ_O));
`default_nettype wire
